/* File: lsl_cluster.sv */
// Four-slice logic cluster with function generators, combiners and storage.
`timescale 1ns/10ps
module lsl_cluster #(
    parameter int N_SLICE_P = 4
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic glob_init,
    input wire logic [N_SLICE_P-1:0][lsl_pkg::LUT_SEL_W-1:0] f_sel,
    input wire logic [N_SLICE_P-1:0][lsl_pkg::LUT_SEL_W-1:0] g_sel,
    input wire logic [N_SLICE_P-1:0] direct_in_lower,
    input wire logic [N_SLICE_P-1:0] opposite_force_in,
    input wire logic [N_SLICE_P-1:0] force_ctl,
    input wire logic [N_SLICE_P-1:0] storage_enable,
    input wire logic [N_SLICE_P-1:0] slice_clk,
    input wire logic [N_SLICE_P-1:0] write_en,
    input wire logic fx_in,
    output logic [N_SLICE_P-1:0] x_out,
    output logic [N_SLICE_P-1:0] y_out,
    output logic [N_SLICE_P-1:0] xq,
    output logic [N_SLICE_P-1:0] yq,
    output logic [N_SLICE_P-1:0] f5_out,
    output logic [N_SLICE_P-1:0] fx_out
);
    import lsl_pkg::*;

    if (N_SLICE_P != N_SLICE) begin : g_bad_slices
        $error("lsl_cluster: the combiner wiring serves exactly four slices");
    end
    if (LUT_DEPTH > 32) begin : g_bad_depth
        $error("lsl_cluster: generator contents must fit one bus word");
    end

    logic [CTRL_W-1:0] ctrl_r [N_SLICE];
    logic dp_wr_r;
    logic rd_wait_r;
    logic [5:0] addr_r;
    logic [31:0] hrdata_r;
    logic init_pend_r;
    logic ap_take;
    logic wr_now;
    logic init_req;
    logic [N_GEN-1:0] gen_out;
    logic [N_GEN-1:0] gen_shift;
    logic [N_GEN-1:0] gen_step;
    logic [N_GEN-1:0] gen_sin;
    logic [N_GEN-1:0] gen_load;
    logic [LUT_DEPTH-1:0] gen_cont [N_GEN];
    logic [N_SLICE-1:0] f5;
    logic [N_SLICE-1:0] fx;
    logic [N_SLICE-1:0] fxa;
    logic [N_SLICE-1:0] fxb;
    logic [N_SLICE-1:0] xq_w;
    logic [N_SLICE-1:0] yq_w;

    // Register bus: writes finish with no wait, reads take one wait state so
    // that a read straight after a write to the same word sees the new value.
    assign ap_take = hsel && hready && htrans[1];
    assign wr_now = dp_wr_r && clk_en;
    assign hreadyout = clk_en && !rd_wait_r;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr_r <= 1'b0;
            rd_wait_r <= 1'b0;
            addr_r <= 6'h00;
        end else if (clk_en) begin
            rd_wait_r <= 1'b0;
            dp_wr_r <= 1'b0;
            if (ap_take) begin
                addr_r <= haddr[7:2];
                // Only whole-word writes are stored; narrower writes are ignored.
                dp_wr_r <= hwrite && (hsize[1:0] == WR_WORD_SIZE) && (haddr[31:8] == 24'h000000);
                rd_wait_r <= !hwrite;
            end
        end
    end

    function automatic logic [31:0] rd_mux(input logic [5:0] idx);
        logic [31:0] v;
        v = 32'h00000000;
        for (int i = 0; i < N_GEN; i++) begin
            if (idx == IDX_LUT_BASE + 6'(i)) begin
                v = 32'(gen_cont[i]);
            end
        end
        for (int i = 0; i < N_SLICE; i++) begin
            if (idx == IDX_CTRL_BASE + 6'(i)) begin
                v = 32'(ctrl_r[i]);
            end
        end
        if (idx == IDX_INIT) begin
            v = 32'(init_pend_r);
        end
        return v;
    endfunction : rd_mux

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h00000000;
        end else if (clk_en && rd_wait_r) begin
            hrdata_r <= rd_mux(addr_r);
        end
    end

    for (genvar i = 0; i < N_SLICE; i++) begin : g_ctrl
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                ctrl_r[i] <= CTRL_RESET;
            end else if (wr_now && addr_r == IDX_CTRL_BASE + 6'(i)) begin
                ctrl_r[i] <= hwdata[CTRL_W-1:0];
            end
        end
    end

    // A global initialisation is pending right after reset and on request.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            init_pend_r <= 1'b1;
        end else if (clk_en) begin
            init_pend_r <= wr_now && addr_r == IDX_INIT && hwdata[0];
        end
    end
    assign init_req = init_pend_r || glob_init;

    // Eight generators, F then G of each slice, linked in one shift chain.
    for (genvar i = 0; i < N_GEN; i++) begin : g_gen
        localparam int S = i / 2;
        localparam int CH = (i % 2 == 0) ? F_CHAIN_F : F_CHAIN_G;
        localparam int MD = (i % 2 == 0) ? F_MODE_F : F_MODE_G;
        logic direct;
        logic chain;
        assign direct = (i % 2 == 0) ? direct_in_lower[S] : opposite_force_in[S];
        if (i == 0) begin : g_first
            assign chain = direct;
        end else begin : g_next
            assign chain = gen_shift[i-1];
        end
        assign gen_sin[i] = ctrl_r[S][CH] ? chain : direct;
        assign gen_load[i] = wr_now && addr_r == IDX_LUT_BASE + 6'(i);
        lsl_func_gen #(
            .SEL_W(LUT_SEL_W),
            .DEPTH(LUT_DEPTH)
        ) u_gen (
            .hclk(hclk),
            .hresetn(hresetn),
            .clk_en(clk_en),
            .mode(lsl_mode_t'(ctrl_r[S][MD +: 2])),
            .sel((i % 2 == 0) ? f_sel[S] : g_sel[S]),
            .step(gen_step[i]),
            .shift_in(gen_sin[i]),
            .load(gen_load[i]),
            .load_data(hwdata[LUT_DEPTH-1:0]),
            .lut_out(gen_out[i]),
            .shift_out(gen_shift[i]),
            .contents(gen_cont[i])
        );
    end

    // Wide combiners: slices 0 and 2 build six inputs, slice 1 seven, slice 3 eight.
    assign fxa[0] = f5[0];
    assign fxb[0] = f5[1];
    assign fxa[1] = fx[0];
    assign fxb[1] = fx[2];
    assign fxa[2] = f5[2];
    assign fxb[2] = f5[3];
    assign fxa[3] = fx[1];
    assign fxb[3] = fx_in;

    function automatic logic stor_nxt(
        input logic q,
        input logic d,
        input logic init_v,
        input logic force_a,
        input logic rev_a,
        input logic force_one,
        input logic async_f,
        input logic capture,
        input logic ce_a
    );
        logic fv;
        fv = force_a ? (force_one && !rev_a) : !force_one;
        if (init_req) begin
            return init_v;
        end else if ((force_a || rev_a) && (async_f || capture)) begin
            return fv;
        end else if (capture && ce_a) begin
            return d;
        end
        return q;
    endfunction : stor_nxt

    for (genvar s = 0; s < N_SLICE; s++) begin : g_slice
        logic clk_act;
        logic clk_prev_r;
        logic edge_w;
        logic capture;
        logic ce_a;
        logic force_a;
        logic rev_a;
        logic we_a;
        logic d_lo;
        logic d_hi;
        logic init_lo;
        logic init_hi;
        logic xq_r;
        logic yq_r;

        // Every control input is compared against its own polarity bit.
        assign clk_act = slice_clk[s] ^ ctrl_r[s][F_INV_CLK];
        assign force_a = force_ctl[s] ^ ctrl_r[s][F_INV_FORCE];
        assign rev_a = ctrl_r[s][F_REV_EN] &&
            (opposite_force_in[s] ^ ctrl_r[s][F_INV_REV]);
        assign ce_a = !ctrl_r[s][F_CE_USED] ||
            (storage_enable[s] ^ ctrl_r[s][F_INV_CE]);
        assign we_a = write_en[s] ^ ctrl_r[s][F_INV_WE];
        assign edge_w = clk_act && !clk_prev_r;
        // The latch copies its input every cycle at the active level, so its
        // output trails the input by one cycle of the system clock.
        assign capture = ctrl_r[s][F_LATCH] ? clk_act : edge_w;

        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                clk_prev_r <= 1'b0;
            end else if (clk_en) begin
                clk_prev_r <= clk_act;
            end
        end

        // RAM writes and shifts happen on the active slice clock edge only.
        assign gen_step[2*s] = edge_w && we_a && ce_a;
        assign gen_step[2*s+1] = edge_w && we_a && ce_a;

        assign f5[s] = direct_in_lower[s] ? gen_out[2*s+1] : gen_out[2*s];
        assign fx[s] = opposite_force_in[s] ? fxb[s] : fxa[s];
        assign x_out[s] = gen_out[2*s];
        assign y_out[s] = gen_out[2*s+1];
        assign f5_out[s] = f5[s];
        assign fx_out[s] = fx[s];

        always_comb begin
            case (ctrl_r[s][F_DSEL_LO +: 2])
                DSEL_COMB: d_lo = f5[s];
                DSEL_DIRECT: d_lo = direct_in_lower[s];
                default: d_lo = gen_out[2*s];
            endcase
            case (ctrl_r[s][F_DSEL_HI +: 2])
                DSEL_COMB: d_hi = fx[s];
                DSEL_DIRECT: d_hi = opposite_force_in[s];
                default: d_hi = gen_out[2*s+1];
            endcase
        end

        assign init_lo = ctrl_r[s][F_INIT_OVR] ? ctrl_r[s][F_INIT_LO] :
            ctrl_r[s][F_FORCE_ONE];
        assign init_hi = ctrl_r[s][F_INIT_OVR] ? ctrl_r[s][F_INIT_HI] :
            ctrl_r[s][F_FORCE_ONE];

        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                xq_r <= 1'b0;
                yq_r <= 1'b0;
            end else if (clk_en) begin
                xq_r <= stor_nxt(xq_r, d_lo, init_lo, force_a, rev_a,
                    ctrl_r[s][F_FORCE_ONE], !ctrl_r[s][F_SYNC], capture, ce_a);
                yq_r <= stor_nxt(yq_r, d_hi, init_hi, force_a, rev_a,
                    ctrl_r[s][F_FORCE_ONE], !ctrl_r[s][F_SYNC], capture, ce_a);
            end
        end
        assign xq_w[s] = xq_r;
        assign yq_w[s] = yq_r;
    end

    assign xq = xq_w;
    assign yq = yq_w;
endmodule : lsl_cluster

/* File: lsl_cluster_props.sv */
// Port checker for the cluster bus handshake and the wide combiner chain.
`timescale 1ns/10ps
module lsl_cluster_props #(
    parameter int N_SLICE_P = 4
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic [N_SLICE_P-1:0] direct_in_lower,
    input wire logic [N_SLICE_P-1:0] x_out,
    input wire logic [N_SLICE_P-1:0] y_out,
    input wire logic [N_SLICE_P-1:0] opposite_force_in,
    input wire logic fx_in,
    input wire logic [N_SLICE_P-1:0] f5_out,
    input wire logic [N_SLICE_P-1:0] fx_out
);
    logic rd_take;
    logic wr_take;
    assign rd_take = hsel && hready && htrans[1] && !hwrite && clk_en;
    assign wr_take = hsel && hready && htrans[1] && hwrite && clk_en;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    okay_resp_a: assert property (hresp == 1'b0) else $error("error response seen");
    read_wait_a: assert property (rd_take |=> !hreadyout ##1 (hreadyout || !clk_en))
        else $error("read wait state wrong");
    write_nowait_a: assert property (wr_take |=> hreadyout || !clk_en)
        else $error("write was stalled");
    clken_stall_a: assert property (!clk_en |-> !hreadyout) else $error("ready while frozen");
    rdata_hold_a: assert property (!$stable(hrdata) |-> !$past(hreadyout))
        else $error("read data moved outside a read");
    fx_low_a: assert property (
        fx_out[0] == (opposite_force_in[0] ? f5_out[1] : f5_out[0])) else $error("fx0 wrong");
    fx_mid_a: assert property (
        fx_out[1] == (opposite_force_in[1] ? fx_out[2] : fx_out[0])) else $error("fx1 wrong");
    fx_top_a: assert property (
        fx_out[3] == (opposite_force_in[3] ? fx_in : fx_out[1])) else $error("fx3 wrong");
    f5_pick_a: assert property (
        f5_out == ((direct_in_lower & y_out) | (~direct_in_lower & x_out)))
        else $error("f5 wrong");
endmodule : lsl_cluster_props

bind lsl_cluster lsl_cluster_props #(.N_SLICE_P(N_SLICE_P)) lsl_cluster_props_i (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .hsel(hsel),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .direct_in_lower(direct_in_lower),
    .x_out(x_out),
    .y_out(y_out),
    .opposite_force_in(opposite_force_in),
    .fx_in(fx_in),
    .f5_out(f5_out),
    .fx_out(fx_out)
);

/* File: lsl_cluster_tb.sv */
// Self-checking testbench for the logic cluster.
`timescale 1ns/10ps
module lsl_cluster_tb;
    import lsl_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic clk_en = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [2:0] hsz = 3'h2;
    logic gi = 1'b0;
    logic hreadyout, hresp;
    logic [31:0] hrdata, rdv;
    logic [3:0][3:0] f_sel, g_sel;
    logic [3:0] dil, ofi, fc, se, sc, we, x_out, y_out, xq, yq;
    int err_count = 0;
    int comparisons = 0;
    always #2.5 hclk = ~hclk;
    lsl_user_logic lsl_user_logic_i (.hclk(hclk), .f_sel(f_sel), .g_sel(g_sel),
        .direct_in_lower(dil), .opposite_force_in(ofi), .force_ctl(fc),
        .storage_enable(se), .slice_clk(sc), .write_en(we));
    lsl_cluster lsl_cluster_i (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsz),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .glob_init(gi), .f_sel(f_sel), .g_sel(g_sel),
        .direct_in_lower(dil), .opposite_force_in(ofi), .force_ctl(fc),
        .storage_enable(se), .slice_clk(sc), .write_en(we), .fx_in(1'b0),
        .x_out(x_out), .y_out(y_out), .xq(xq), .yq(yq), .f5_out(), .fx_out());
    task automatic summarize();
        if (err_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Ready is tested at each rising edge; each phase ends at the edge that finds it high.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rdv = hrdata;
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rdv, exp);
    endtask : rd
    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask : tick
    function automatic logic [31:0] q2();
        return {30'h0, xq[0], yq[0]};
    endfunction : q2
    initial begin
        repeat (5000) @(posedge hclk);
        err_count++;
        summarize();
    end
    initial begin
        tick(8);
        hresetn <= 1'b1;
        rd(8'h20, 32'h0);
        rd(8'h40, 32'h0);
        hsz <= 3'h0;
        bus(1'b1, 8'h20, 32'h1f);
        hsz <= 3'h2;
        rd(8'h20, 32'h0);
        bus(1'b1, 8'h00, 32'h6996);
        bus(1'b1, 8'h04, 32'h8001);
        rd(8'h00, 32'h6996);
        for (int s = 0; s < 16; s++) begin
            lsl_user_logic_i.drive(4'(s), 5'h0);
            @(negedge hclk);
            chk({31'h0, x_out[0]}, {31'h0, ^4'(s)});
            chk({31'h0, y_out[0]}, {31'h0, s == 0 || s == 15});
            @(posedge hclk);
        end
        lsl_user_logic_i.drive(4'h1, 5'h0);
        lsl_user_logic_i.pulse();
        chk(q2(), 32'h2);
        lsl_user_logic_i.drive(4'h0, 5'h0);
        tick(3);
        chk(q2(), 32'h2);
        lsl_user_logic_i.pulse();
        chk(q2(), 32'h1);
        bus(1'b1, 8'h20, 32'h10010);
        lsl_user_logic_i.drive(4'h1, 5'h0);
        tick(2);
        chk(q2(), 32'h2);
        lsl_user_logic_i.drive(4'h0, 5'h0);
        tick(2);
        chk(q2(), 32'h1);
        bus(1'b1, 8'h20, 32'h10);
        lsl_user_logic_i.drive(4'h1, 5'h0);
        tick(3);
        chk(q2(), 32'h1);
        bus(1'b1, 8'h20, 32'h8000);
        lsl_user_logic_i.drive(4'h1, 5'h0);
        lsl_user_logic_i.pulse();
        chk(q2(), 32'h1);
        bus(1'b1, 8'h20, 32'h28000);
        lsl_user_logic_i.pulse();
        chk(q2(), 32'h2);
        bus(1'b1, 8'h20, 32'h200);
        lsl_user_logic_i.drive(4'h1, 5'h04);
        tick(2);
        chk(q2(), 32'h3);
        bus(1'b1, 8'h20, 32'h0);
        tick(2);
        chk(q2(), 32'h0);
        bus(1'b1, 8'h20, 32'h4000);
        lsl_user_logic_i.drive(4'h1, 5'h02);
        tick(2);
        chk({31'h0, xq[0]}, 32'h1);
        lsl_user_logic_i.drive(4'h1, 5'h06);
        tick(2);
        chk({31'h0, xq[0]}, 32'h0);
        bus(1'b1, 8'h20, 32'h4200);
        tick(2);
        chk({31'h0, xq[0]}, 32'h0);
        bus(1'b1, 8'h20, 32'h2200);
        lsl_user_logic_i.drive(4'h0, 5'h04);
        tick(3);
        chk({31'h0, xq[0]}, 32'h0);
        lsl_user_logic_i.pulse();
        chk(q2(), 32'h3);
        bus(1'b1, 8'h20, 32'h1600);
        lsl_user_logic_i.drive(4'h0, 5'h0);
        bus(1'b1, 8'h30, 32'h1);
        tick(3);
        chk(q2(), 32'h1);
        bus(1'b1, 8'h20, 32'h200);
        bus(1'b1, 8'h30, 32'h1);
        tick(3);
        chk(q2(), 32'h3);
        rd(8'h30, 32'h0);
        bus(1'b1, 8'h20, 32'h40);
        lsl_user_logic_i.drive(4'h1, 5'h0);
        lsl_user_logic_i.pulse();
        chk({31'h0, xq[0]}, 32'h0);
        bus(1'b1, 8'h00, 32'h0);
        bus(1'b1, 8'h20, 32'h1);
        lsl_user_logic_i.drive(4'h5, 5'h09);
        lsl_user_logic_i.pulse();
        rd(8'h00, 32'h20);
        chk({31'h0, x_out[0]}, 32'h1);
        bus(1'b1, 8'h00, 32'h8000);
        bus(1'b1, 8'h04, 32'h0);
        bus(1'b1, 8'h20, 32'h40000a);
        lsl_user_logic_i.drive(4'h0, 5'h09);
        lsl_user_logic_i.pulse();
        rd(8'h00, 32'h1);
        rd(8'h04, 32'h1);
        chk({31'h0, x_out[0]}, 32'h1);
        clk_en <= 1'b0;
        lsl_user_logic_i.pulse();
        clk_en <= 1'b1;
        rd(8'h00, 32'h1);
        bus(1'b1, 8'h20, 32'h1600);
        gi <= 1'b1;
        tick(2);
        chk(q2(), 32'h1);
        gi <= 1'b0;
        summarize();
    end
endmodule : lsl_cluster_tb

/* File: lsl_func_gen.sv */
// Shared constants for the logic cluster and the 16-entry function generator.
package lsl_pkg;
    localparam int N_SLICE = 4;
    localparam int N_GEN = 2 * N_SLICE;
    localparam int LUT_SEL_W = 4;
    localparam int LUT_DEPTH = 16;
    localparam int CTRL_W = 23;
    // Byte addresses on the register bus, then the word indices that they decode to.
    localparam logic [7:0] ADDR_LUT_BASE = 8'h00;
    localparam logic [7:0] ADDR_CTRL_BASE = 8'h20;
    localparam logic [7:0] ADDR_INIT = 8'h30;
    localparam logic [5:0] IDX_LUT_BASE = 6'h00;
    localparam logic [5:0] IDX_CTRL_BASE = 6'h08;
    localparam logic [5:0] IDX_INIT = 6'h0c;
    // Field positions within each slice control word.
    localparam int F_MODE_F = 0;
    localparam int F_MODE_G = 2;
    localparam int F_LATCH = 4;
    localparam int F_DSEL_LO = 5;
    localparam int F_DSEL_HI = 7;
    localparam int F_FORCE_ONE = 9;
    localparam int F_INIT_OVR = 10;
    localparam int F_INIT_LO = 11;
    localparam int F_INIT_HI = 12;
    localparam int F_SYNC = 13;
    localparam int F_REV_EN = 14;
    localparam int F_CE_USED = 15;
    localparam int F_INV_CLK = 16;
    localparam int F_INV_CE = 17;
    localparam int F_INV_FORCE = 18;
    localparam int F_INV_REV = 19;
    localparam int F_INV_WE = 20;
    localparam int F_CHAIN_F = 21;
    localparam int F_CHAIN_G = 22;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 23'h000000;
    localparam logic [LUT_DEPTH-1:0] LUT_RESET = 16'h0000;
    localparam logic [1:0] DSEL_LUT = 2'h0;
    localparam logic [1:0] DSEL_COMB = 2'h1;
    localparam logic [1:0] DSEL_DIRECT = 2'h2;
    localparam logic [1:0] WR_WORD_SIZE = 2'h2;
    typedef enum logic [1:0] {MODE_LUT, MODE_RAM, MODE_SHIFT} lsl_mode_t;
endpackage : lsl_pkg

`timescale 1ns/10ps
module lsl_func_gen #(
    parameter int SEL_W = 4,
    parameter int DEPTH = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire lsl_pkg::lsl_mode_t mode,
    input wire logic [SEL_W-1:0] sel,
    input wire logic step,
    input wire logic shift_in,
    input wire logic load,
    input wire logic [DEPTH-1:0] load_data,
    output logic lut_out,
    output logic shift_out,
    output logic [DEPTH-1:0] contents
);
    import lsl_pkg::*;

    logic [DEPTH-1:0] mem_r;

    if (DEPTH != (1 << SEL_W)) begin : g_bad_depth
        $error("lsl_func_gen: DEPTH must equal two to the power SEL_W");
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mem_r <= '0;
        end else if (clk_en) begin
            if (load) begin
                mem_r <= load_data;
            end else if (step) begin
                case (mode)
                    MODE_RAM: mem_r[sel] <= shift_in;
                    MODE_SHIFT: mem_r <= {mem_r[DEPTH-2:0], shift_in};
                    default: ;
                endcase
            end
        end
    end

    // The same index picks a truth-table entry, a RAM word or a shift tap.
    assign lut_out = mem_r[sel];
    assign shift_out = mem_r[DEPTH-1];
    assign contents = mem_r;
endmodule : lsl_func_gen

/* File: lsl_user_logic.sv */
// Behavioural model of the user logic that drives the slice pins.
`timescale 1ns/10ps
module lsl_user_logic (
    input wire logic hclk,
    output logic [3:0][lsl_pkg::LUT_SEL_W-1:0] f_sel,
    output logic [3:0][lsl_pkg::LUT_SEL_W-1:0] g_sel,
    output logic [3:0] direct_in_lower,
    output logic [3:0] opposite_force_in,
    output logic [3:0] force_ctl,
    output logic [3:0] storage_enable,
    output logic [3:0] slice_clk,
    output logic [3:0] write_en
);
    import lsl_pkg::*;
    initial begin
        f_sel = '0;
        g_sel = '0;
        direct_in_lower = '0;
        opposite_force_in = '0;
        force_ctl = '0;
        storage_enable = '0;
        slice_clk = '0;
        write_en = '0;
    end
    // All four slices get the same pattern; v is {enable, write, force, opposite, direct}.
    task automatic drive(input logic [LUT_SEL_W-1:0] s, input logic [4:0] v);
        f_sel <= {4{s}};
        g_sel <= {4{s}};
        direct_in_lower <= {4{v[0]}};
        opposite_force_in <= {4{v[1]}};
        force_ctl <= {4{v[2]}};
        write_en <= {4{v[3]}};
        storage_enable <= {4{v[4]}};
    endtask : drive
    // The slice clock stays low between bursts so every capture is a deliberate one.
    task automatic pulse();
        @(posedge hclk);
        slice_clk <= '1;
        @(posedge hclk);
        slice_clk <= '0;
        repeat (2) @(posedge hclk);
    endtask : pulse
endmodule : lsl_user_logic
